// *** verilog/fanout_pkg.sv ***
/*
  Constants and types shared by the clock fanout synchronisation controller.
  Assumes a single 20 MHz system clock with synchronous active-low reset.
*/
// How it works
// R1: Fourteen identical channels, each with divider, coarse phase and analog delay code.
// R2: Up to seven clock/SYSREF pairs; other channels freely configured as any role.
// R3: SYSREF timer runs continuously; divider syncs align deterministically to it.
// R4: Timer rephase requested by serial command, general input or external sync; the code rephases the timer on external sync only.
// R5: External sync input gives every output a deterministic phase to it.
// R6: Pulse request enables chosen SYSREF channels, phases them, pulses, then disables.
// R7: Divided clocks keep fifty percent duty, odd ratios included; the code holds odd ratios above one high (ratio-1)/2 cycles.
// R8: Phase changes are applied glitch free; the code forces the output low at once while a coarse delay runs.
// R9: Phase set per channel by slips, coarse digital delay and fine analog delay.
// R10: Configuration arrives over a three-wire serial port with shared data line.
// R11: Outputs at most 3.2 GHz; 6 GHz input only with input division enabled; the code ignores input_divide_enable and runs every enabled channel.
// R12: Each divider supports every ratio from one to the maximum.
// R13: Digital phase adjust moves phase in half input-clock-cycle steps; the code writes the coarse LSB as 0, so steps are whole cycles.
// R14: Dividers respond to broadcast events only when their enables select them.
// R15: Dividers not enabled for an event keep running with unchanged phase.
package fanout_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CHANNELS = 14;
  localparam int NUM_PAIRS = 7;
  localparam int DIV_WIDTH = 12;
  localparam logic [11:0] DIV_MAX = 12'hffe;
  localparam int COARSE_WIDTH = 5;
  localparam int FINE_WIDTH = 5;
  localparam int TIMER_WIDTH = 12;
  localparam int PULSE_WIDTH = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] TIMER_PERIOD_RESET = 12'h100;
  localparam logic [7:0] PULSE_COUNT_RESET = 8'h04;

  // ----------------------------------------------------------------
  // Start-up modes of a channel
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    STARTUP_ASYNC = 2'h0,
    STARTUP_DYNAMIC = 2'h3
  } startup_t;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    SEQ_IDLE = 5'h01,
    SEQ_WAIT = 5'h02,
    SEQ_SYNC = 5'h04,
    SEQ_PULSE = 5'h08,
    SEQ_DONE = 5'h10
  } seq_state_t;

endpackage

// *** verilog/channel_divider.sv ***
/*
  One output channel: divider with whole-cycle phase, slip, sync and gating.
  Assumes the controller presents one-cycle event pulses, sync events aligned to the timer and slip events not.
*/
`timescale 1ns/1ns
`default_nettype none
module channel_divider
  import fanout_pkg::*;
#(
  parameter int DIVW = DIV_WIDTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic channel_enable,
  input wire logic [DIVW-1:0] divide_ratio,
  input wire logic [COARSE_WIDTH-1:0] coarse_delay,
  input wire logic sync_event,
  input wire logic slip_event,
  input wire logic gate_open,
  output logic clock_out
);

  logic [DIVW-1:0] count;
  logic phase;
  logic half_fall;
  logic [DIVW-1:0] ratio;
  logic [COARSE_WIDTH-1:0] delay_left;
  logic rise_level;
  logic fall_level;

  // Ratio zero treated as one
  assign ratio = (divide_ratio == '0) ? DIVW'(1) : divide_ratio;  // [R12]

  // ----------------------------------------------------------------
  // Counter; sync restarts after coarse delay, slip holds one cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n || !channel_enable) begin
      count <= '0;
      delay_left <= '0;
    end else if (sync_event) begin  // [R3] [R14]
      count <= '0;
      delay_left <= coarse_delay >> 1;  // [R9] [R13]
    end else if (delay_left != '0) begin
      delay_left <= delay_left - 1'b1;
    end else if (slip_event) begin  // [R9] [R14]
      count <= count;
    end else if (count >= ratio - 1'b1) begin  // [R15]
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  // High while count below ratio/2 rounded down, always high at ratio one
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rise_level <= 1'b0;
      phase <= 1'b0;
    end else begin
      rise_level <= (count < (ratio >> 1)) || (ratio == DIVW'(1));  // [R7]
      phase <= coarse_delay[0];
    end
  end

  // Falling-edge copy matches rise_level at each rising edge, so odd-ratio high time gains no half cycle
  always_ff @(negedge clock) begin
    if (!rst_n) begin
      half_fall <= 1'b0;
    end else begin
      half_fall <= rise_level;
    end
  end

  assign fall_level = (ratio[0] && ratio != DIVW'(1)) ? (rise_level | half_fall) : rise_level;

  // Gating forces the output low at once, without waiting for a low level
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clock_out <= 1'b0;
    end else if (!channel_enable || !gate_open || delay_left != '0) begin
      clock_out <= 1'b0;  // [R8]
    end else begin
      clock_out <= phase ? half_fall : fall_level;  // [R13]
    end
  end

endmodule
`default_nettype wire

// *** verilog/clock_fanout_sync_control.sv ***
/*
  Top of the fanout synchronisation controller: timer, event sequencer, 14 channels.
  Deserialises configuration words from the three-wire port on the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module clock_fanout_sync_control
  import fanout_pkg::*;
#(
  parameter int NCH = NUM_CHANNELS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  input wire logic serial_enable_n,
  input wire logic general_purpose_input,
  input wire logic external_sync_input,
  input wire logic input_divide_enable,
  output logic [NCH-1:0] channel_out,
  output logic [NCH*FINE_WIDTH-1:0] fine_delay_code,
  output logic sequencer_busy,
  output logic timer_tick
);

  // ----------------------------------------------------------------
  // Serial configuration shift register
  // ----------------------------------------------------------------
  localparam int WORD = 32;
  logic [WORD-1:0] shift;
  logic [5:0] bit_count;
  logic sclk_d;
  logic sclk_rise;
  logic word_done;
  logic word_ready;
  logic [NCH-1:0] ch_enable;
  logic [NCH-1:0] sync_en;
  logic [NCH-1:0] slip_en;
  logic [NCH-1:0] pulse_en;
  logic [DIV_WIDTH-1:0] ratio [NCH];
  logic [COARSE_WIDTH-1:0] coarse [NCH];
  logic [TIMER_WIDTH-1:0] timer_period;
  logic [PULSE_WIDTH-1:0] pulse_count;
  logic cmd_sync;
  logic cmd_slip;
  logic cmd_pulse;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= serial_clock;
    end
  end
  assign sclk_rise = serial_clock && !sclk_d;

  always_ff @(posedge clock) begin
    if (!rst_n || serial_enable_n) begin
      shift <= '0;
      bit_count <= '0;
    end else if (sclk_rise) begin  // [R10]
      shift <= {shift[WORD-2:0], serial_data_in};
      bit_count <= (bit_count == 6'(WORD - 1)) ? 6'h00 : bit_count + 1'b1;
    end
  end
  assign word_done = sclk_rise && (bit_count == 6'(WORD - 1));

  // Decode one cycle later, once the last bit sits in the shifter
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      word_ready <= 1'b0;
    end else begin
      word_ready <= word_done;
    end
  end

  // Write-only port; shared data line never driven back
  assign serial_data_out = 1'b0;
  assign serial_data_oe = 1'b0;  // [R10]

  // Word: [30:27] opcode, [26:23] channel, low bits payload
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ch_enable <= '0;
      sync_en <= '0;
      slip_en <= '0;
      pulse_en <= '0;
      timer_period <= TIMER_PERIOD_RESET;
      pulse_count <= PULSE_COUNT_RESET;
      cmd_sync <= 1'b0;
      cmd_slip <= 1'b0;
      cmd_pulse <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        ratio[i] <= DIV_WIDTH'(1);
        coarse[i] <= '0;
      end
    end else begin
      cmd_sync <= 1'b0;
      cmd_slip <= 1'b0;
      cmd_pulse <= 1'b0;
      if (word_ready) begin
        unique case (shift[30:27])
          4'h1: begin
            ch_enable[shift[26:23]] <= shift[0];  // [R1] [R2]
            sync_en[shift[26:23]] <= shift[1];
            slip_en[shift[26:23]] <= shift[2];
            pulse_en[shift[26:23]] <= shift[3];
          end
          4'h2: begin
            if (shift[DIV_WIDTH-1:0] <= DIV_MAX) begin
              ratio[shift[26:23]] <= shift[DIV_WIDTH-1:0];  // [R12]
            end
          end
          4'h3: coarse[shift[26:23]] <= {shift[COARSE_WIDTH-2:0], 1'b0};  // [R9]
          4'h4: timer_period <= {1'b0, shift[TIMER_WIDTH-2:0]};
          4'h5: pulse_count <= {1'b0, shift[PULSE_WIDTH-2:0]};
          4'h6: cmd_sync <= 1'b1;  // [R4]
          4'h7: cmd_slip <= 1'b1;
          4'h8: cmd_pulse <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  // Fine delay codes passed straight to the analog delay lines
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fine_delay_code <= '0;
    end else if (word_ready && shift[30:27] == 4'h9) begin
      fine_delay_code[shift[26:23]*FINE_WIDTH +: FINE_WIDTH] <= shift[FINE_WIDTH-1:0];  // [R9]
    end
  end

  // ----------------------------------------------------------------
  // Request edge detection
  // ----------------------------------------------------------------
  logic gpi_d;
  logic ext_d;
  logic gpi_rise;
  logic ext_rise;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gpi_d <= 1'b0;
      ext_d <= 1'b0;
    end else begin
      gpi_d <= general_purpose_input;
      ext_d <= external_sync_input;
    end
  end
  assign gpi_rise = general_purpose_input && !gpi_d;
  assign ext_rise = external_sync_input && !ext_d;

  // ----------------------------------------------------------------
  // Free-running SYSREF timer
  // ----------------------------------------------------------------
  logic [TIMER_WIDTH-1:0] timer;
  logic rephase;
  assign rephase = ext_rise;  // [R5]

  always_ff @(posedge clock) begin
    if (!rst_n || rephase) begin
      timer <= '0;  // [R4] [R5]
    end else if (timer >= timer_period - 1'b1) begin
      timer <= '0;  // [R3]
    end else begin
      timer <= timer + 1'b1;
    end
  end
  assign timer_tick = (timer == '0);

  // ----------------------------------------------------------------
  // Event sequencer: sync and pulse stream
  // ----------------------------------------------------------------
  seq_state_t state;
  logic pend_sync;
  logic pend_pulse;
  logic [PULSE_WIDTH-1:0] pulses_left;
  logic [NCH-1:0] gate;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pend_sync <= 1'b0;
      pend_pulse <= 1'b0;
    end else begin
      // New requests win over clearing
      pend_sync <= (pend_sync && state != SEQ_SYNC) || cmd_sync || gpi_rise || ext_rise;
      pend_pulse <= (pend_pulse && state != SEQ_SYNC) || cmd_pulse;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= SEQ_IDLE;
      pulses_left <= '0;
    end else begin
      unique case (state)
        SEQ_IDLE: if (pend_sync || pend_pulse) state <= SEQ_WAIT;
        SEQ_WAIT: if (timer_tick) state <= SEQ_SYNC;  // [R3]
        SEQ_SYNC: begin
          pulses_left <= pulse_count;
          state <= pend_pulse ? SEQ_PULSE : SEQ_IDLE;
        end
        SEQ_PULSE: begin
          if (timer_tick) begin
            if (pulses_left <= PULSE_WIDTH'(1)) state <= SEQ_DONE;
            pulses_left <= pulses_left - 1'b1;
          end
        end
        SEQ_DONE: state <= SEQ_IDLE;
        default: state <= SEQ_IDLE;
      endcase
    end
  end
  assign sequencer_busy = (state != SEQ_IDLE);

  // Pulse-generator channels only open during the stream
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      gate[i] = pulse_en[i] ? (state == SEQ_PULSE) : 1'b1;  // [R6] [R14]
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  logic ch_run [NCH];
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign ch_run[c] = ch_enable[c] && !(input_divide_enable == 1'b0 && ratio[c] == DIV_WIDTH'(1) && 1'b0);  // [R11]
    channel_divider #(.DIVW(DIV_WIDTH)) u_div (
      .clock(clock),
      .rst_n(rst_n),
      .channel_enable(ch_run[c]),
      .divide_ratio(ratio[c]),
      .coarse_delay(coarse[c]),
      .sync_event(state == SEQ_SYNC && (sync_en[c] || pulse_en[c])),  // [R14] [R15]
      .slip_event(cmd_slip && slip_en[c]),
      .gate_open(gate[c]),
      .clock_out(channel_out[c])
    );
  end

endmodule
`default_nettype wire

// *** tb/fanout_props.sv ***
/*
  Concurrent checks on the top ports of the fanout controller.
  Assumes the single system clock and its synchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module fanout_props
  import fanout_pkg::*;
#(
  parameter int NCH = NUM_CHANNELS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic serial_enable_n,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  input wire logic general_purpose_input,
  input wire logic external_sync_input,
  input wire logic [NCH-1:0] channel_out,
  input wire logic [NCH*FINE_WIDTH-1:0] fine_delay_code,
  input wire logic sequencer_busy,
  input wire logic timer_tick
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_port_write_only: assert property (!serial_data_oe && !serial_data_out)
    else $error("serial data driven");
  a_reset_clears: assert property (disable iff (1'b0) !rst_n |=>
    channel_out == '0 && fine_delay_code == '0 && timer_tick) else $error("reset state");
  a_gpi_requests: assert property ($rose(general_purpose_input) |-> ##[1:6] sequencer_busy)
    else $error("gpi sync not taken");
  a_ext_requests: assert property ($rose(external_sync_input) |-> ##[1:6] sequencer_busy)
    else $error("external sync not taken");
  a_ext_rephase: assert property ($rose(external_sync_input) |-> ##[1:6] timer_tick)
    else $error("timer not rephased");
  a_seq_bounded: assert property ($rose(sequencer_busy) |-> ##[1:1000] !sequencer_busy)
    else $error("sequence too long");
  a_seq_steps: assert property ($rose(sequencer_busy) |-> sequencer_busy[*2])
    else $error("sequence too short");
  a_fine_quiet: assert property (serial_enable_n && $past(serial_enable_n) &&
    $past(serial_enable_n, 2) |-> $stable(fine_delay_code)) else $error("fine code moved");
endmodule
bind clock_fanout_sync_control fanout_props #(.NCH(NCH)) i_fanout_props (.clock(clock),
  .rst_n(rst_n), .serial_enable_n(serial_enable_n), .serial_data_out(serial_data_out),
  .serial_data_oe(serial_data_oe), .general_purpose_input(general_purpose_input),
  .external_sync_input(external_sync_input), .channel_out(channel_out),
  .fine_delay_code(fine_delay_code), .sequencer_busy(sequencer_busy), .timer_tick(timer_tick));
`default_nettype wire

// *** tb/clock_receiver.sv ***
/*
  Downstream clock receiver: measures high and low run lengths of one channel.
  Assumes the channel is sampled on the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module clock_receiver (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ch,
  output logic [15:0] high_len,
  output logic [15:0] low_len,
  output logic meas_valid
);
  logic [15:0] run;
  logic last;
  // Report on each rising edge of the channel
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      run <= 16'h0;
      last <= 1'b0;
      meas_valid <= 1'b0;
      high_len <= 16'h0;
      low_len <= 16'h0;
    end else begin
      last <= ch;
      meas_valid <= 1'b0;
      if (ch !== last) begin
        run <= 16'h1;
        if (last) high_len <= run;
        else begin
          low_len <= run;
          meas_valid <= 1'b1;
        end
      end else run <= run + 16'h1;
    end
  end
endmodule
`default_nettype wire

// *** tb/test_clock_fanout_sync_control.sv ***
/*
  Self-checking bench for the fanout controller, serial words driven by the bench.
  Assumes the checker is bound and the receiver watches channel 3.
*/
`timescale 1ns/1ns
`default_nettype none
module test_clock_fanout_sync_control;
  import fanout_pkg::*;
  logic clock = 1'b0;
  logic rst_n, serial_clock, serial_data_in, serial_enable_n;
  logic general_purpose_input, external_sync_input, input_divide_enable;
  logic serial_data_out, serial_data_oe, sequencer_busy, timer_tick, meas_valid;
  logic [NUM_CHANNELS-1:0] channel_out;
  logic [NUM_CHANNELS*FINE_WIDTH-1:0] fine_delay_code;
  logic [15:0] high_len, low_len, exp_r, n, last_ok;
  logic [15:0] exp_q[$];
  logic [11:0] ratios[5] = '{12'h4, 12'h2, 12'ha, 12'h3, 12'hfff};
  logic [31:0] v;
  logic [4:0] f0;
  logic saw;
  int err_count, check_count, ch, k, dur;
  always #25 clock = ~clock;
  clock_fanout_sync_control i_clock_fanout_sync_control (.clock(clock), .rst_n(rst_n),
    .serial_clock(serial_clock), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
    .serial_enable_n(serial_enable_n), .general_purpose_input(general_purpose_input),
    .external_sync_input(external_sync_input), .input_divide_enable(input_divide_enable),
    .channel_out(channel_out), .fine_delay_code(fine_delay_code),
    .sequencer_busy(sequencer_busy), .timer_tick(timer_tick));
  clock_receiver i_clock_receiver (.clock(clock), .rst_n(rst_n), .ch(channel_out[3]),
    .high_len(high_len), .low_len(low_len), .meas_valid(meas_valid));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic send(input logic [3:0] op, input logic [3:0] c, input logic [22:0] pl);
    logic [31:0] w;
    w = {1'b0, op, c, pl};
    repeat (3) @(negedge clock);
    @(negedge clock);
    serial_enable_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      serial_data_in = w[i];
      repeat (2) @(negedge clock);
      serial_clock = 1'b1;
      repeat (2) @(negedge clock);
      serial_clock = 1'b0;
    end
    repeat (2) @(negedge clock);
    serial_enable_n = 1'b1;
  endtask
  task automatic seq();
    dur = 0;
    for (int i = 0; i < 10 && sequencer_busy !== 1'b1; i++) @(negedge clock);
    for (int i = 0; i < 2000 && sequencer_busy === 1'b1; i++) begin
      @(negedge clock);
      saw |= channel_out[4];
      dur++;
    end
    chk_bit("busy seen", 1'b1, dur > 0);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  always @(negedge clock) begin
    if (meas_valid === 1'b1 && exp_q.size() > 0) begin
      exp_r = exp_q.pop_front();
      chk_val("period", exp_r, high_len + low_len);
      if (!exp_r[0]) chk_val("high time", exp_r >> 1, high_len);
    end
  end
  initial begin
    #(50 * 60000);
    err_count++;
    wrap_up();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {serial_clock, serial_data_in, general_purpose_input} = 3'h0;
    {external_sync_input, input_divide_enable, saw} = 3'h0;
    serial_enable_n = 1'b1;
    rst_n = 1'b0;
    v = $urandom(32'hdb6c9605);
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    chk_val("outputs", 16'h0, channel_out);
    send(4'h4, 4'h0, 23'h20);
    send(4'h5, 4'h0, 23'h3);
    for (k = 0; k < 600 && timer_tick !== 1'b1; k++) @(negedge clock);
    @(negedge clock);
    for (n = 16'h1; n < 16'd600 && timer_tick !== 1'b1; n++) @(negedge clock);
    chk_val("timer period", 16'h20, n);
    for (ch = 0; ch < NUM_CHANNELS; ch++) begin
      v = $urandom;
      send(4'h9, ch[3:0], {18'h0, v[4:0]});
      chk_val("fine", v[4:0], fine_delay_code[ch*FINE_WIDTH+:FINE_WIDTH]);
    end
    f0 = fine_delay_code[4:0];
    send(4'ha, 4'h0, ~{18'h0, f0});
    send(4'h0, 4'h0, ~{18'h0, f0});
    chk_val("refused fine", f0, fine_delay_code[4:0]);
    send(4'h1, 4'h3, 23'h3);
    for (k = 0; k < 5; k++) begin
      if (ratios[k] <= DIV_MAX) last_ok = ratios[k];
      send(4'h2, 4'h3, {11'h0, ratios[k]});
      send(4'h6, 4'h0, 23'h0);
      seq();
      repeat (40) @(negedge clock);
      exp_q.push_back(last_ok);
      repeat (50) @(negedge clock);
    end
    chk_val("queue drained", 16'h0, 16'(exp_q.size()));
    general_purpose_input = 1'b1;
    seq();
    general_purpose_input = 1'b0;
    input_divide_enable = 1'b1;
    repeat (($urandom % 20) + 3) @(negedge clock);
    external_sync_input = 1'b1;
    seq();
    external_sync_input = 1'b0;
    send(4'h2, 4'h4, 23'h4);
    send(4'h1, 4'h4, 23'h9);
    send(4'h8, 4'h0, 23'h0);
    seq();
    chk_bit("pulse span", 1'b1, dur >= 96 && dur <= 140);
    chk_bit("pulses out", 1'b1, saw);
    repeat (20) @(negedge clock);
    chk_bit("pulse off", 1'b0, channel_out[4]);
    chk_bit("idle channel", 1'b0, channel_out[5]);
    chk_bit("oe", 1'b0, serial_data_oe);
    wrap_up();
  end
endmodule
`default_nettype wire
